// ### pkg/cbrf_params.svh
`ifndef CBRF_PARAMS_SVH
`define CBRF_PARAMS_SVH

// Register word offsets on the bus (byte addresses, one word each).
`define CBRF_OFS_PC        8'h00
`define CBRF_OFS_SP        8'h04
`define CBRF_OFS_WIDE      8'h08
`define CBRF_OFS_PGACC     8'h0C
`define CBRF_OFS_PAIR1     8'h10
`define CBRF_OFS_PAIR2     8'h14
`define CBRF_OFS_PAIR3     8'h18
`define CBRF_OFS_BANKS     8'h1C
// Added to a main-bank offset to reach the same register in the shadow bank.
`define CBRF_OFS_SHADOW    8'h20

// Field positions.
`define CBRF_PAGE_LSB      8
`define CBRF_ACC_SEL_BIT   0
`define CBRF_GEN_SEL_BIT   1

// Reset values and steps.
`define CBRF_PC_RST        16'h0000
`define CBRF_SP_RST        16'h0000
`define CBRF_BANK_SEL_RST  1'b0
`define CBRF_SP_STEP       16'h0002

`endif

// ### pkg/cbrf_pkg.sv
`default_nettype none
package cbrf_pkg;

    typedef struct packed {
        logic [15:0] wide;
        logic [7:0]  page;
        logic [7:0]  acc;
    } cbrf_acc_grp_t;

    typedef struct packed {
        logic [15:0] first;
        logic [15:0] second;
        logic [15:0] third;
    } cbrf_gen_grp_t;

    typedef enum logic [1:0] {CBRF_PC_HOLD, CBRF_PC_STEP, CBRF_PC_LOAD} cbrf_pc_op_t;
    typedef enum logic [1:0] {CBRF_SRC_IMM, CBRF_SRC_WIDE, CBRF_SRC_FIRST,
                              CBRF_SRC_THIRD} cbrf_pc_src_t;
    typedef enum logic [1:0] {CBRF_SP_HOLD, CBRF_SP_PUSH, CBRF_SP_POP} cbrf_sp_op_t;
    typedef enum logic [1:0] {CBRF_PAIR_FIRST, CBRF_PAIR_SECOND,
                              CBRF_PAIR_THIRD} cbrf_pair_t;
    typedef enum logic [1:0] {CBRF_PTR_PLAIN, CBRF_PTR_INC1, CBRF_PTR_DEC1,
                              CBRF_PTR_INC2} cbrf_ptr_mode_t;

    // Only the second and third pairs carry base and auto-step addressing.
    function automatic logic cbrf_is_base_pair(input cbrf_pair_t p);
        return (p == CBRF_PAIR_SECOND) || (p == CBRF_PAIR_THIRD);
    endfunction : cbrf_is_base_pair

endpackage : cbrf_pkg
`default_nettype wire

// ### core/cbrf_bank_pair.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbrf_params.svh"
// Two copies of a register group; a swap only flips which copy is active,
// so the exchange is complete in one edge and can never be seen half done.
module cbrf_bank_pair
    import cbrf_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_swap,
    input  wire logic [W-1:0] i_act_mask,
    input  wire logic [W-1:0] i_act_data,
    input  wire logic [W-1:0] i_shd_mask,
    input  wire logic [W-1:0] i_shd_data,
    output logic              o_sel,
    output logic [W-1:0]      o_act,
    output logic [W-1:0]      o_shd
);
    logic sel_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sel_r <= `CBRF_BANK_SEL_RST;
        end else if (i_swap) begin
            sel_r <= ~sel_r;
        end
    end

    // Contents carry no reset; writes in a swap cycle land in the copy that
    // was active before that swap.
    for (genvar k = 0; k < 2; k++) begin : g_copy
        logic [W-1:0] val_r;
        wire logic          is_act = (sel_r == 1'(k));
        wire logic [W-1:0] mask_k = is_act ? i_act_mask : i_shd_mask;
        wire logic [W-1:0] data_k = is_act ? i_act_data : i_shd_data;
        always_ff @(posedge i_clk) begin
            val_r <= (val_r & ~mask_k) | (data_k & mask_k);
        end
    end

    assign o_sel = sel_r;
    assign o_act = sel_r ? g_copy[1].val_r : g_copy[0].val_r;
    assign o_shd = sel_r ? g_copy[0].val_r : g_copy[1].val_r;

endmodule : cbrf_bank_pair
`default_nettype wire

// ### core/cbrf_ptr_calc.sv
`timescale 1ns/1ps
`default_nettype none
// Post-access step of a data pointer pair and its base-plus-displacement address.
module cbrf_ptr_calc
    import cbrf_pkg::*;
(
    input  wire logic           i_is_base,
    input  wire cbrf_ptr_mode_t i_mode,
    input  wire logic [15:0]    i_pair_val,
    input  wire logic [7:0]     i_disp,
    output logic [15:0]         o_next,
    output logic [15:0]         o_base_addr
);
    wire logic [15:0] step_val = (i_mode == CBRF_PTR_INC1) ? 16'h0001 :
                                 (i_mode == CBRF_PTR_DEC1) ? 16'hFFFF :
                                 (i_mode == CBRF_PTR_INC2) ? 16'h0002 : 16'h0000;

    // The first pair never steps, whatever mode it is given.
    assign o_next      = i_is_base ? 16'(i_pair_val + step_val) : i_pair_val;
    assign o_base_addr = 16'(i_pair_val + {8'h00, i_disp});

endmodule : cbrf_ptr_calc
`default_nettype wire

// ### core/cbrf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbrf_params.svh"
module cbrf_top
    import cbrf_pkg::*;
#(
    parameter logic [15:0] SP_STEP = `CBRF_SP_STEP
) (
    input  wire logic           I_REF_CLK,
    input  wire logic           I_RST,
    input  wire logic [7:0]     I_AVS_ADDRESS,
    input  wire logic           I_AVS_READ,
    input  wire logic           I_AVS_WRITE,
    input  wire logic [31:0]    I_AVS_WRITEDATA,
    input  wire logic [3:0]     I_AVS_BYTEENABLE,
    output logic [31:0]         O_AVS_READDATA,
    output logic                O_AVS_WAITREQUEST,
    input  wire logic           I_SWAP_ACC,
    input  wire logic           I_SWAP_GEN,
    input  wire logic           I_INT_ENTRY,
    input  wire logic           I_BANKED_CTX,
    input  wire cbrf_pc_op_t    I_PC_OP,
    input  wire cbrf_pc_src_t   I_PC_SRC,
    input  wire logic [2:0]     I_INSN_LEN,
    input  wire logic [15:0]    I_PC_IMM,
    input  wire cbrf_sp_op_t    I_SP_OP,
    input  wire logic           I_PTR_REQ,
    input  wire cbrf_pair_t     I_PTR_PAIR,
    input  wire cbrf_ptr_mode_t I_PTR_MODE,
    input  wire logic [7:0]     I_DISP,
    input  wire logic [7:0]     I_WORK_IMM,
    output logic [15:0]         O_PC,
    output logic [15:0]         O_SP,
    output cbrf_acc_grp_t       O_ACC_GRP,
    output logic [15:0]         O_WORK_ADDR,
    output logic [15:0]         O_PTR_ADDR,
    output logic [15:0]         O_BASE_ADDR,
    output logic                O_ACC_BANK,
    output logic                O_GEN_BANK
);

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    function automatic logic [47:0] pair_mask(input cbrf_pair_t p, input logic [15:0] m);
        return (p == CBRF_PAIR_FIRST)  ? {m, 32'h0000_0000} :
               (p == CBRF_PAIR_SECOND) ? {16'h0000, m, 16'h0000} :
               (p == CBRF_PAIR_THIRD)  ? {32'h0000_0000, m} : 48'h0000_0000_0000;
    endfunction : pair_mask

    function automatic logic [15:0] pair_of(input cbrf_gen_grp_t g, input cbrf_pair_t p);
        return (p == CBRF_PAIR_FIRST)  ? g.first :
               (p == CBRF_PAIR_SECOND) ? g.second : g.third;
    endfunction : pair_of

    logic [15:0]   pc_r;
    logic [15:0]   sp_r;
    logic [31:0]   rdata_r;
    logic          rd_ack_r;
    logic [15:0]   work_addr_r;
    logic [15:0]   ptr_addr_r;
    logic [15:0]   base_addr_r;
    cbrf_acc_grp_t acc_act;
    cbrf_acc_grp_t acc_shd;
    cbrf_gen_grp_t gen_act;
    cbrf_gen_grp_t gen_shd;
    logic          acc_sel;
    logic          gen_sel;
    logic [15:0]   ptr_next;
    logic [15:0]   base_calc;

    // Core operations own the registers in their cycle; a bus write waits.
    wire logic core_busy = I_SWAP_ACC | I_SWAP_GEN | I_INT_ENTRY | I_PTR_REQ
                         | (I_PC_OP != CBRF_PC_HOLD) | (I_SP_OP != CBRF_SP_HOLD);
    wire logic        wr_go = I_AVS_WRITE & ~core_busy;
    wire logic [31:0] bmask = be_mask(I_AVS_BYTEENABLE);
    wire logic [15:0] wd16  = I_AVS_WRITEDATA[15:0];
    wire logic [15:0] bm16  = bmask[15:0];

    wire logic a_pc     = (I_AVS_ADDRESS == `CBRF_OFS_PC);
    wire logic a_sp     = (I_AVS_ADDRESS == `CBRF_OFS_SP);
    wire logic a_wide   = (I_AVS_ADDRESS == `CBRF_OFS_WIDE);
    wire logic a_pgacc  = (I_AVS_ADDRESS == `CBRF_OFS_PGACC);
    wire logic a_p1     = (I_AVS_ADDRESS == `CBRF_OFS_PAIR1);
    wire logic a_p2     = (I_AVS_ADDRESS == `CBRF_OFS_PAIR2);
    wire logic a_p3     = (I_AVS_ADDRESS == `CBRF_OFS_PAIR3);
    wire logic a_banks  = (I_AVS_ADDRESS == `CBRF_OFS_BANKS);
    wire logic a_wide_s = (I_AVS_ADDRESS == 8'(`CBRF_OFS_WIDE + `CBRF_OFS_SHADOW));
    wire logic a_pgac_s = (I_AVS_ADDRESS == 8'(`CBRF_OFS_PGACC + `CBRF_OFS_SHADOW));
    wire logic a_p1_s   = (I_AVS_ADDRESS == 8'(`CBRF_OFS_PAIR1 + `CBRF_OFS_SHADOW));
    wire logic a_p2_s   = (I_AVS_ADDRESS == 8'(`CBRF_OFS_PAIR2 + `CBRF_OFS_SHADOW));
    wire logic a_p3_s   = (I_AVS_ADDRESS == 8'(`CBRF_OFS_PAIR3 + `CBRF_OFS_SHADOW));

    // Accumulator group: bus writes only, split into wide half and page/acc half.
    wire logic [31:0] acc_act_mask = wr_go ? ({a_wide ? bm16 : 16'h0000,
                                               a_pgacc ? bm16 : 16'h0000}) : 32'h0000_0000;
    wire logic [31:0] acc_shd_mask = wr_go ? ({a_wide_s ? bm16 : 16'h0000,
                                               a_pgac_s ? bm16 : 16'h0000}) : 32'h0000_0000;
    wire logic [31:0] acc_wdata    = {wd16, wd16};

    // A context switch on interrupt entry flips both groups in the same edge.
    wire logic int_swap = I_INT_ENTRY & I_BANKED_CTX;
    wire logic acc_swap = I_SWAP_ACC | int_swap;
    wire logic gen_swap = I_SWAP_GEN | int_swap;

    cbrf_bank_pair #(
        .W          (32)
    ) u_acc_bank (
        .i_clk      (I_REF_CLK),
        .i_rst      (I_RST),
        .i_swap     (acc_swap),
        .i_act_mask (acc_act_mask),
        .i_act_data (acc_wdata),
        .i_shd_mask (acc_shd_mask),
        .i_shd_data (acc_wdata),
        .o_sel      (acc_sel),
        .o_act      (acc_act),
        .o_shd      (acc_shd)
    );

    // General group: bus writes or a pointer step; never both in one cycle.
    wire logic       ptr_base = cbrf_is_base_pair(I_PTR_PAIR);
    wire logic       ptr_go   = I_PTR_REQ & ptr_base & (I_PTR_MODE != CBRF_PTR_PLAIN);
    wire cbrf_pair_t av_pair  = (a_p1 | a_p1_s) ? CBRF_PAIR_FIRST :
                                (a_p2 | a_p2_s) ? CBRF_PAIR_SECOND : CBRF_PAIR_THIRD;
    wire logic       av_main  = a_p1 | a_p2 | a_p3;
    wire logic       av_shd   = a_p1_s | a_p2_s | a_p3_s;
    wire logic [47:0] gen_act_mask = ((wr_go & av_main) ? pair_mask(av_pair, bm16)
                                                        : 48'h0000_0000_0000)
                                   | (ptr_go ? pair_mask(I_PTR_PAIR, 16'hFFFF)
                                             : 48'h0000_0000_0000);
    wire logic [47:0] gen_shd_mask = (wr_go & av_shd) ? pair_mask(av_pair, bm16)
                                                      : 48'h0000_0000_0000;
    wire logic [47:0] gen_wdata    = ptr_go ? {3{ptr_next}} : {3{wd16}};

    cbrf_bank_pair #(
        .W          (48)
    ) u_gen_bank (
        .i_clk      (I_REF_CLK),
        .i_rst      (I_RST),
        .i_swap     (gen_swap),
        .i_act_mask (gen_act_mask),
        .i_act_data (gen_wdata),
        .i_shd_mask (gen_shd_mask),
        .i_shd_data (gen_wdata),
        .o_sel      (gen_sel),
        .o_act      (gen_act),
        .o_shd      (gen_shd)
    );

    wire logic [15:0] ptr_val = pair_of(gen_act, I_PTR_PAIR);

    cbrf_ptr_calc u_ptr_calc (
        .i_is_base   (ptr_base),
        .i_mode      (I_PTR_MODE),
        .i_pair_val  (ptr_val),
        .i_disp      (I_DISP),
        .o_next      (ptr_next),
        .o_base_addr (base_calc)
    );

    // Program counter and stack pointer next values.
    wire logic [15:0] pc_load = (I_PC_SRC == CBRF_SRC_IMM)   ? I_PC_IMM :
                                (I_PC_SRC == CBRF_SRC_WIDE)  ? acc_act.wide :
                                (I_PC_SRC == CBRF_SRC_FIRST) ? gen_act.first
                                                             : gen_act.third;
    wire logic [15:0] pc_nxt  = (I_PC_OP == CBRF_PC_LOAD) ? pc_load :
                                (I_PC_OP == CBRF_PC_STEP) ? 16'(pc_r + 16'(I_INSN_LEN)) :
                                (wr_go & a_pc) ? ((pc_r & ~bm16) | (wd16 & bm16)) : pc_r;
    wire logic        sp_down = (I_SP_OP == CBRF_SP_PUSH) | I_INT_ENTRY;
    wire logic [15:0] sp_nxt  = sp_down ? 16'(sp_r - SP_STEP) :
                                (I_SP_OP == CBRF_SP_POP) ? 16'(sp_r + SP_STEP) :
                                (wr_go & a_sp) ? ((sp_r & ~bm16) | (wd16 & bm16)) : sp_r;

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            pc_r <= `CBRF_PC_RST;
            sp_r <= `CBRF_SP_RST;
        end else begin
            pc_r <= pc_nxt;
            sp_r <= sp_nxt;
        end
    end

    // Read path: unmapped offsets read as zero.
    wire logic [31:0] banks_val = (32'(acc_sel) << `CBRF_ACC_SEL_BIT)
                                | (32'(gen_sel) << `CBRF_GEN_SEL_BIT);
    wire logic [31:0] rd_mux =
        a_pc     ? {16'h0000, pc_r} :
        a_sp     ? {16'h0000, sp_r} :
        a_wide   ? {16'h0000, acc_act.wide} :
        a_pgacc  ? {16'h0000, acc_act.page, acc_act.acc} :
        a_p1     ? {16'h0000, gen_act.first} :
        a_p2     ? {16'h0000, gen_act.second} :
        a_p3     ? {16'h0000, gen_act.third} :
        a_banks  ? banks_val :
        a_wide_s ? {16'h0000, acc_shd.wide} :
        a_pgac_s ? {16'h0000, acc_shd.page, acc_shd.acc} :
        a_p1_s   ? {16'h0000, gen_shd.first} :
        a_p2_s   ? {16'h0000, gen_shd.second} :
        a_p3_s   ? {16'h0000, gen_shd.third} : 32'h0000_0000;

    // Reads take two cycles so the read data leave a flip-flop.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            rd_ack_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
        end else begin
            rd_ack_r <= I_AVS_READ & ~rd_ack_r;
            if (I_AVS_READ & ~rd_ack_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign O_AVS_WAITREQUEST = I_AVS_READ ? ~rd_ack_r : (I_AVS_WRITE & core_busy);
    assign O_AVS_READDATA    = rdata_r;

    // Address outputs for the memory stage.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            work_addr_r <= 16'h0000;
            ptr_addr_r  <= 16'h0000;
            base_addr_r <= 16'h0000;
        end else begin
            work_addr_r <= {acc_act.page, I_WORK_IMM};
            if (I_PTR_REQ) begin
                ptr_addr_r <= ptr_val;
            end
            if (I_PTR_REQ & ptr_base) begin
                base_addr_r <= base_calc;
            end
        end
    end

    assign O_PC        = pc_r;
    assign O_SP        = sp_r;
    assign O_ACC_GRP   = acc_act;
    assign O_WORK_ADDR = work_addr_r;
    assign O_PTR_ADDR  = ptr_addr_r;
    assign O_BASE_ADDR = base_addr_r;
    assign O_ACC_BANK  = acc_sel;
    assign O_GEN_BANK  = gen_sel;

    pc_reset_a: assert property (@(posedge I_REF_CLK) I_RST |=> pc_r == 16'h0000)
        else $error("program counter not cleared under reset");

    pc_step_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_PC_OP == CBRF_PC_STEP |=> pc_r == 16'($past(pc_r) + 16'($past(I_INSN_LEN))))
        else $error("program counter did not advance by instruction length");

    pc_branch_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_PC_OP == CBRF_PC_LOAD && I_PC_SRC == CBRF_SRC_IMM |=> pc_r == $past(I_PC_IMM))
        else $error("branch did not load the target");

    sp_push_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        (I_SP_OP == CBRF_SP_PUSH || I_INT_ENTRY) |=> sp_r == 16'($past(sp_r) - SP_STEP))
        else $error("stack pointer did not move down on push");

    sp_pop_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_SP_OP == CBRF_SP_POP && !I_INT_ENTRY |=> sp_r == 16'($past(sp_r) + SP_STEP))
        else $error("stack pointer did not move up on pop");

    acc_swap_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        acc_swap |=> acc_act == $past(acc_shd) && acc_shd == $past(acc_act))
        else $error("accumulator group not exchanged in one edge");

    gen_swap_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        gen_swap && !ptr_go |=> gen_act == $past(gen_shd) && gen_shd == $past(gen_act))
        else $error("general pairs not exchanged together");

    int_bank_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_INT_ENTRY && I_BANKED_CTX && !I_SWAP_ACC && !I_SWAP_GEN
        |=> acc_sel != $past(acc_sel) && gen_sel != $past(gen_sel))
        else $error("interrupt entry did not switch banks");

    work_addr_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        !acc_swap |=> O_WORK_ADDR == {$past(acc_act.page), $past(I_WORK_IMM)})
        else $error("working address not page and immediate");

    ptr_inc2_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        ptr_go && I_PTR_MODE == CBRF_PTR_INC2 && !gen_swap
        |=> pair_of(gen_act, $past(I_PTR_PAIR)) == 16'($past(ptr_val) + 16'h0002)
            && O_PTR_ADDR == $past(ptr_val))
        else $error("two-step increment wrong");

    first_fixed_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_PTR_REQ && I_PTR_PAIR == CBRF_PAIR_FIRST && !I_AVS_WRITE && !gen_swap
        |=> gen_act.first == $past(gen_act.first) && O_BASE_ADDR == $past(O_BASE_ADDR))
        else $error("first pair stepped or used as base");

    pc_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_PC_OP == CBRF_PC_HOLD && !(wr_go && a_pc) |=> pc_r == $past(pc_r))
        else $error("program counter moved without a step or branch");

    pc_wide_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_PC_OP == CBRF_PC_LOAD && I_PC_SRC == CBRF_SRC_WIDE |=> pc_r == $past(acc_act.wide))
        else $error("branch did not load the wide accumulator");

    pc_third_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_PC_OP == CBRF_PC_LOAD && I_PC_SRC == CBRF_SRC_THIRD |=> pc_r == $past(gen_act.third))
        else $error("branch did not load the third pair");

    sp_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_SP_OP == CBRF_SP_HOLD && !I_INT_ENTRY && !(wr_go && a_sp) |=> sp_r == $past(sp_r))
        else $error("stack pointer moved without a stack operation");

    base_addr_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_PTR_REQ && ptr_base |=> O_BASE_ADDR == 16'($past(ptr_val) + {8'h00, $past(I_DISP)}))
        else $error("base address not pair plus displacement");

    ptr_inc1_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        ptr_go && I_PTR_MODE == CBRF_PTR_INC1 && !gen_swap
        |=> pair_of(gen_act, $past(I_PTR_PAIR)) == 16'($past(ptr_val) + 16'h0001))
        else $error("single-step increment wrong");

    ptr_dec1_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        ptr_go && I_PTR_MODE == CBRF_PTR_DEC1 && !gen_swap
        |=> pair_of(gen_act, $past(I_PTR_PAIR)) == 16'($past(ptr_val) - 16'h0001))
        else $error("single-step decrement wrong");

    shd_write_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        wr_go && a_p2_s && I_AVS_BYTEENABLE[1:0] == 2'h3 && !gen_swap
        |=> gen_shd.second == $past(wd16))
        else $error("shadow pair write did not land");

endmodule : cbrf_top
`default_nettype wire

// ### verif/cbrf_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cbrf_top_tb
    import cbrf_pkg::*;
;
    localparam logic [15:0] STEP = 16'h0002;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic [7:0]     avs_addr = 8'h00;
    logic           avs_rd = 1'b0;
    logic           avs_wr = 1'b0;
    logic [31:0]    avs_wdata = 32'h0000_0000;
    logic [31:0]    avs_rdata;
    logic           avs_wait;
    logic           swap_acc = 1'b0;
    logic           swap_gen = 1'b0;
    logic           int_entry = 1'b0;
    logic           banked = 1'b0;
    cbrf_pc_op_t    pc_op = CBRF_PC_HOLD;
    cbrf_pc_src_t   pc_src = CBRF_SRC_IMM;
    logic [2:0]     insn_len = 3'h0;
    logic [15:0]    pc_imm = 16'h1234;
    cbrf_sp_op_t    sp_op = CBRF_SP_HOLD;
    logic           ptr_req = 1'b0;
    cbrf_pair_t     ptr_pair = CBRF_PAIR_FIRST;
    cbrf_ptr_mode_t ptr_mode = CBRF_PTR_PLAIN;
    logic [7:0]     disp = 8'h00;
    logic [7:0]     work_imm = 8'h00;
    logic [15:0]    pc, sp, work_addr, ptr_addr, base_addr, cur, exp_pc;
    cbrf_acc_grp_t  acc_grp;
    logic           acc_bank, gen_bank;
    logic [31:0]    rd_val;
    int             error_cnt = 0;
    int             n_compared = 0;
    logic [15:0]    stp [4] = '{16'h0000, 16'h0001, 16'hFFFF, 16'h0002};
    logic [15:0]    ld_exp [4] = '{16'h1234, 16'h1111, 16'h0102, 16'h0506};

    cbrf_top #(.SP_STEP(STEP)) DUT (
        .I_REF_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(avs_addr), .I_AVS_READ(avs_rd),
        .I_AVS_WRITE(avs_wr), .I_AVS_WRITEDATA(avs_wdata), .I_AVS_BYTEENABLE(4'hF),
        .O_AVS_READDATA(avs_rdata), .O_AVS_WAITREQUEST(avs_wait), .I_SWAP_ACC(swap_acc),
        .I_SWAP_GEN(swap_gen), .I_INT_ENTRY(int_entry), .I_BANKED_CTX(banked),
        .I_PC_OP(pc_op), .I_PC_SRC(pc_src), .I_INSN_LEN(insn_len), .I_PC_IMM(pc_imm),
        .I_SP_OP(sp_op), .I_PTR_REQ(ptr_req), .I_PTR_PAIR(ptr_pair), .I_PTR_MODE(ptr_mode),
        .I_DISP(disp), .I_WORK_IMM(work_imm), .O_PC(pc), .O_SP(sp), .O_ACC_GRP(acc_grp),
        .O_WORK_ADDR(work_addr), .O_PTR_ADDR(ptr_addr), .O_BASE_ADDR(base_addr),
        .O_ACC_BANK(acc_bank), .O_GEN_BANK(gen_bank)
    );

    always #25 clk = ~clk;

    task automatic print_verdict();
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Strobes last exactly one cycle; outputs are judged mid-cycle, clear of the edge.
    task automatic settle();
        @(posedge clk);
        swap_acc <= 1'b0;
        swap_gen <= 1'b0;
        int_entry <= 1'b0;
        ptr_req <= 1'b0;
        pc_op <= CBRF_PC_HOLD;
        sp_op <= CBRF_SP_HOLD;
        @(negedge clk);
    endtask : settle

    // Waitrequest and read data are taken at the rising edge that accepts the request.
    task automatic bus_wait();
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (avs_wait === 1'b0) break;
        end
        if (n == 50) begin
            error_cnt++;
            print_verdict();
        end else begin
            rd_val = avs_rdata;
            avs_rd <= 1'b0;
            avs_wr <= 1'b0;
        end
    endtask : bus_wait

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_addr <= a;
        avs_wdata <= d;
        avs_wr <= 1'b1;
        bus_wait();
    endtask : bus_wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        avs_addr <= a;
        avs_rd <= 1'b1;
        bus_wait();
        chk(rd_val, exp);
    endtask : rd_chk

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({16'h0000, pc}, 32'h0);
        rd_chk(8'h00, 32'h0);
        bus_wr(8'h08, 32'h1111);
        bus_wr(8'h0C, 32'h2233);
        bus_wr(8'h28, 32'hAAAA);
        bus_wr(8'h2C, 32'hBBCC);
        bus_wr(8'h10, 32'h0102);
        bus_wr(8'h14, 32'h0304);
        bus_wr(8'h18, 32'h0506);
        bus_wr(8'h30, 32'hF1F2);
        bus_wr(8'h34, 32'hF3F4);
        bus_wr(8'h38, 32'hF5F6);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            pc_op <= CBRF_PC_LOAD;
            pc_src <= cbrf_pc_src_t'(s[1:0]);
            settle();
            chk({16'h0000, pc}, {16'h0000, ld_exp[s]});
        end
        exp_pc = 16'h0506;
        for (int l = 1; l < 8; l++) begin
            @(posedge clk);
            pc_op <= CBRF_PC_STEP;
            insn_len <= l[2:0];
            settle();
            exp_pc = exp_pc + 16'(l);
            chk({16'h0000, pc}, {16'h0000, exp_pc});
        end
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({16'h0000, pc}, 32'h0);
        chk(acc_grp, 32'h1111_2233);
        @(posedge clk);
        swap_acc <= 1'b1;
        work_imm <= 8'h5A;
        settle();
        chk(acc_grp, 32'hAAAA_BBCC);
        chk({31'h0, acc_bank}, 32'h1);
        settle();
        chk({16'h0000, work_addr}, 32'hBB5A);
        @(posedge clk);
        swap_acc <= 1'b1;
        settle();
        chk(acc_grp, 32'h1111_2233);
        for (int p = 1; p < 3; p++) begin
            cur = (p == 1) ? 16'h0304 : 16'h0506;
            for (int m = 0; m < 4; m++) begin
                @(posedge clk);
                ptr_req <= 1'b1;
                ptr_pair <= cbrf_pair_t'(p[1:0]);
                ptr_mode <= cbrf_ptr_mode_t'(m[1:0]);
                disp <= 8'hFF;
                settle();
                chk({16'h0000, ptr_addr}, {16'h0000, cur});
                chk({16'h0000, base_addr}, {16'h0000, cur + 16'h00FF});
                cur = cur + stp[m];
                rd_chk({p[5:0], 2'b00} + 8'h10, {16'h0000, cur});
            end
        end
        @(posedge clk);
        ptr_req <= 1'b1;
        ptr_pair <= CBRF_PAIR_FIRST;
        ptr_mode <= CBRF_PTR_INC2;
        settle();
        rd_chk(8'h10, 32'h0102);
        @(posedge clk);
        swap_gen <= 1'b1;
        settle();
        chk({30'h0, gen_bank, acc_bank}, 32'h2);
        rd_chk(8'h10, 32'hF1F2);
        rd_chk(8'h18, 32'hF5F6);
        rd_chk(8'h38, {16'h0000, cur});
        bus_wr(8'h04, 32'h0100);
        @(posedge clk);
        int_entry <= 1'b1;
        banked <= 1'b1;
        settle();
        chk({16'h0000, sp}, 32'h00FE);
        chk({30'h0, gen_bank, acc_bank}, 32'h1);
        @(posedge clk);
        int_entry <= 1'b1;
        banked <= 1'b0;
        settle();
        chk({14'h0, gen_bank, acc_bank, sp}, 32'h0001_00FC);
        @(posedge clk);
        sp_op <= CBRF_SP_PUSH;
        settle();
        chk({16'h0000, sp}, 32'h00FA);
        @(posedge clk);
        sp_op <= CBRF_SP_POP;
        settle();
        chk({16'h0000, sp}, 32'h00FC);
        bus_wr(8'h40, 32'h5555);
        rd_chk(8'h40, 32'h0);
        bus_wr(8'h1C, 32'h0);
        rd_chk(8'h1C, 32'h1);
        print_verdict();
    end
endmodule : cbrf_top_tb
`default_nettype wire
